// File: hw/dsf_adc_end.sv
// converter end: strobe capture, relock tracking, sample fifo and lane serializer
`timescale 1ns/1ps
module dsf_adc_end #(
    parameter int LOCK_CYCLES = dsf_pkg::PLL_LOCK_CYCLES,
    parameter int FIFO_DEPTH = dsf_pkg::FIFO_DEPTH
) (
    // clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // configuration
    input wire logic programming_method_select,
    input wire logic dcs_disable_req,
    input wire dsf_pkg::dsf_lane_t lane_mode,
    input wire dsf_pkg::dsf_ser_t ser_width,
    // conversion results from the core
    input wire logic sample_valid,
    output logic sample_ready,
    input wire logic [dsf_pkg::DATA_W-1:0] chan1_sample,
    input wire logic chan1_over_pos,
    input wire logic [dsf_pkg::DATA_W-1:0] chan2_sample,
    input wire logic chan2_over_pos,
    // status
    output logic pll_locked,
    output logic dcs_active,
    output logic sample_missed,
    // serial link
    dsf_link_if.adc link
);
    localparam int LW = $clog2(LOCK_CYCLES + 1);
    localparam int PW = dsf_pkg::PER_W;
    localparam int CW = dsf_pkg::CNT_W;
    localparam int WW = dsf_pkg::WORD_W;
    localparam int PHW = (dsf_pkg::BIT_DIV > 1) ? $clog2(dsf_pkg::BIT_DIV) : 1;

    typedef enum logic {
        ST_IDLE = 1'h0,
        ST_SHIFT = 1'h1
    } dsf_state_t;

    ////////////////////////////////////////////////////////////////////////////
    // strobe synchronisers, first stage read only by the second
    logic pos_s1_reg;
    logic pos_s2_reg;
    logic pos_s3_reg;
    logic neg_s1_reg;
    logic neg_s2_reg;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            pos_s1_reg <= 1'b0;
            pos_s2_reg <= 1'b0;
            pos_s3_reg <= 1'b0;
            neg_s1_reg <= 1'b1;
            neg_s2_reg <= 1'b1;
        end else begin
            pos_s1_reg <= link.sample_strobe_pos;
            pos_s2_reg <= pos_s1_reg;
            pos_s3_reg <= pos_s2_reg;
            neg_s1_reg <= link.sample_strobe_neg;
            neg_s2_reg <= neg_s1_reg;
        end
    end

    // stabilizer forced on under pin straps
    wire dcs_on = programming_method_select | ~dcs_disable_req;
    // with the stabilizer only the positive rise counts, so duty is free
    // without it the complement must agree, which makes duty matter
    wire pos_rise = pos_s2_reg & ~pos_s3_reg;
    wire strobe_rise = pos_rise & (dcs_on | ~neg_s2_reg);

    ////////////////////////////////////////////////////////////////////////////
    // relock tracking: a period change or a stopped strobe restarts the wait
    logic [PW-1:0] period_cnt_reg;
    logic [PW-1:0] last_period_reg;
    logic [LW-1:0] lock_cnt_reg;
    wire stalled = (period_cnt_reg == PW'(dsf_pkg::STOP_CYCLES));
    wire [PW-1:0] diff = (period_cnt_reg > last_period_reg) ?
                         period_cnt_reg - last_period_reg : last_period_reg - period_cnt_reg;
    wire period_bad = strobe_rise & (diff > PW'(dsf_pkg::PERIOD_TOL));
    wire lock_done = (lock_cnt_reg == LW'(LOCK_CYCLES));

    // period measure, saturating at the stop limit
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            period_cnt_reg <= '0;
            last_period_reg <= '0;
        end else if (strobe_rise) begin
            period_cnt_reg <= PW'(1);
            last_period_reg <= period_cnt_reg;
        end else if (!stalled) begin
            period_cnt_reg <= period_cnt_reg + 1'b1;
        end
    end

    // lock wait counter
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            lock_cnt_reg <= '0;
            pll_locked <= 1'b0;
        end else begin
            if (period_bad || stalled) begin
                lock_cnt_reg <= '0;
            end else if (!lock_done) begin
                lock_cnt_reg <= lock_cnt_reg + 1'b1;
            end
            pll_locked <= lock_done & ~period_bad & ~stalled;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sample fifo: drained only by locked strobes, so it backs up the core
    logic fifo_valid;
    logic [dsf_pkg::FIFO_W-1:0] fifo_data;
    wire pop = strobe_rise & pll_locked & fifo_valid;

    dsf_sample_fifo #(
        .WIDTH(dsf_pkg::FIFO_W),
        .DEPTH(FIFO_DEPTH)
    ) dsf_sample_fifo_inst (
        .mclk(mclk),
        .nrst(nrst),
        .in_valid(sample_valid),
        .in_ready(sample_ready),
        .in_data({chan1_over_pos, chan1_sample, chan2_over_pos, chan2_sample}),
        .out_valid(fifo_valid),
        .out_ready(pop),
        .out_data(fifo_data)
    );

    ////////////////////////////////////////////////////////////////////////////
    // mode decode
    wire two_lane = (lane_mode == dsf_pkg::LANES2);
    wire half_frame = two_lane & (ser_width == dsf_pkg::SER14);
    wire [CW-1:0] bpl = dsf_pkg::bits_per_lane(lane_mode, ser_width);
    wire [WW-1:0] word1 = dsf_pkg::frame_word(fifo_data[24:13], fifo_data[25], ser_width);
    wire [WW-1:0] word2 = dsf_pkg::frame_word(fifo_data[11:0], fifo_data[12], ser_width);

    ////////////////////////////////////////////////////////////////////////////
    // serializer state
    dsf_state_t state_reg;
    logic [PHW-1:0] ph_reg;
    logic [CW-1:0] bits_left_reg;
    logic [CW-1:0] bpl_reg;
    logic two_lane_reg;
    logic half_reg;
    logic parity_reg;
    logic fbc_reg;
    logic marker_reg;
    logic [WW-1:0] sh_reg [2];
    logic [1:0] first_reg;
    logic [1:0] second_reg;

    // bit slots come from a divider: one cycle pulses at fixed phases
    wire shifting = (state_reg == ST_SHIFT);
    wire bit_en = (state_reg == ST_SHIFT) & (ph_reg == '0);
    wire clk_en = (state_reg == ST_SHIFT) & (ph_reg == PHW'(dsf_pkg::BIT_PHASE));
    wire [CW-1:0] bit_idx = bpl_reg - bits_left_reg;
    // marker high over the first half of a word, or whole alternate words
    wire marker_bit = half_reg ? parity_reg : (bit_idx < (bpl_reg >> 1));

    // sequencing of words and bit slots
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= ST_IDLE;
            ph_reg <= '0;
            bits_left_reg <= '0;
            bpl_reg <= '0;
            two_lane_reg <= 1'b0;
            half_reg <= 1'b0;
            parity_reg <= 1'b0;
        end else if (pop) begin
            // a new strobe always restarts on a word boundary
            state_reg <= ST_SHIFT;
            ph_reg <= '0;
            bits_left_reg <= bpl;
            bpl_reg <= bpl;
            two_lane_reg <= two_lane;
            half_reg <= half_frame;
            parity_reg <= ~parity_reg;
        end else if (state_reg == ST_SHIFT) begin
            ph_reg <= (ph_reg == PHW'(dsf_pkg::BIT_DIV - 1)) ? '0 : ph_reg + 1'b1;
            if (bit_en) begin
                bits_left_reg <= bits_left_reg - 1'b1;
            end
            if (clk_en && bits_left_reg == '0) begin
                state_reg <= ST_IDLE;
            end
        end
    end

    // bit clock toggles mid slot so both edges land on stable data
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            fbc_reg <= 1'b0;
            marker_reg <= 1'b0;
        end else begin
            if (clk_en) begin
                fbc_reg <= ~fbc_reg;
            end
            if (bit_en) begin
                marker_reg <= marker_bit;
            end
        end
    end

    // per channel shifters, both loaded from the same strobe
    for (genvar c = 0; c < 2; c++) begin : g_chan
        always_ff @(posedge mclk or negedge nrst) begin
            if (!nrst) begin
                sh_reg[c] <= '0;
                first_reg[c] <= 1'b0;
                second_reg[c] <= 1'b0;
            end else if (pop) begin
                sh_reg[c] <= (c == 0) ? word1 : word2;
            end else if (bit_en) begin
                first_reg[c] <= sh_reg[c][WW-1];
                second_reg[c] <= two_lane_reg & sh_reg[c][WW-2];
                sh_reg[c] <= two_lane_reg ? {sh_reg[c][WW-3:0], 2'h0}
                                          : {sh_reg[c][WW-2:0], 1'h0};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // status flags
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            dcs_active <= 1'b1;
            sample_missed <= 1'b0;
        end else begin
            dcs_active <= dcs_on;
            sample_missed <= strobe_rise & pll_locked & ~fifo_valid & ~shifting;
        end
    end

    // link outputs straight from flops
    assign link.forwarded_bit_clock = fbc_reg;
    assign link.frame_marker = marker_reg;
    assign link.chan1_first_lane = first_reg[0];
    assign link.chan1_second_lane = second_reg[0];
    assign link.chan2_first_lane = first_reg[1];
    assign link.chan2_second_lane = second_reg[1];
endmodule : dsf_adc_end

// File: hw/dsf_pkg.sv
// shared constants, mode types and word helpers for the dual converter serial framer
package dsf_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // clock and timing
    localparam int MCLK_MHZ = 200;
    localparam int PLL_LOCK_US = 25;
    // relock wait in mclk cycles, a least time rounded up
    localparam int PLL_LOCK_CYCLES = (PLL_LOCK_US * MCLK_MHZ * 1000 + 999) / 1000;
    localparam int MIN_RATE_MSPS = 5;
    // longest strobe period allowed, rounded down
    localparam int MAX_STROBE_CYCLES = MCLK_MHZ / MIN_RATE_MSPS;
    // strobe gap that counts as a stopped strobe
    localparam int STOP_CYCLES = 2 * MAX_STROBE_CYCLES;
    localparam int PERIOD_TOL = 1;
    // mclk cycles per serial bit, and the phase where the bit clock toggles
    localparam int BIT_DIV = 2;
    localparam int BIT_PHASE = 1;
    localparam int LANE_MAX_MBPS = 1000;
    localparam int LANE_RATE_MBPS = MCLK_MHZ / BIT_DIV;
    // spare cycles between the end of a word and the next strobe
    localparam int STROBE_MARGIN = 2;
    // fastest grade limit on the strobe, in MHz
    localparam int GRADE_MAX_MHZ = 125;
    localparam int GRADE_MIN_CYCLES = (MCLK_MHZ + GRADE_MAX_MHZ - 1) / GRADE_MAX_MHZ;

    ////////////////////////////////////////////////////////////////////////////
    // data layout
    localparam int DATA_W = 12;
    localparam int WORD_W = 16;
    localparam int FIFO_DEPTH = 8;
    localparam int FIFO_W = 2 * (DATA_W + 1);
    localparam int CNT_W = 5;
    localparam int PER_W = 8;

    typedef enum logic [1:0] {
        SER16 = 2'h0,
        SER14 = 2'h1,
        SER12 = 2'h2
    } dsf_ser_t;

    typedef enum logic {
        LANES2 = 1'h0,
        LANES1 = 1'h1
    } dsf_lane_t;

    ////////////////////////////////////////////////////////////////////////////
    // bits sent on each lane per sample
    function automatic logic [CNT_W-1:0] bits_per_lane(dsf_lane_t lanes, dsf_ser_t width);
        logic [CNT_W-1:0] total;
        total = (width == SER16) ? 5'h10 : (width == SER14) ? 5'h0e : 5'h0c;
        return (lanes == LANES2) ? (total >> 1) : total;
    endfunction : bits_per_lane

    // left aligned word: data, two overrange pad bits except in 12 bit, then zero fill
    function automatic logic [WORD_W-1:0] frame_word(logic [DATA_W-1:0] d, logic ovr,
                                                     dsf_ser_t width);
        return (width == SER12) ? {d, 4'h0} : {d, {2{ovr}}, 2'h0};
    endfunction : frame_word

    // received word right aligned: returns overrange flag and data
    function automatic logic [DATA_W:0] decode_word(logic [WORD_W-1:0] w, dsf_ser_t width);
        logic [DATA_W:0] r;
        r = {1'h0, w[11:0]};
        if (width == SER14) begin
            r = {&w[1:0], w[13:2]};
        end else if (width == SER16) begin
            r = {&w[3:2], w[15:4]};
        end
        return r;
    endfunction : decode_word

endpackage : dsf_pkg

// File: hw/dsf_link_if.sv
// serial link between the converter end and the deserializer end
`timescale 1ns/1ps
interface dsf_link_if;
    logic sample_strobe_pos;
    logic sample_strobe_neg;
    logic forwarded_bit_clock;
    logic frame_marker;
    logic chan1_first_lane;
    logic chan1_second_lane;
    logic chan2_first_lane;
    logic chan2_second_lane;

    modport adc (
        input sample_strobe_pos,
        input sample_strobe_neg,
        output forwarded_bit_clock,
        output frame_marker,
        output chan1_first_lane,
        output chan1_second_lane,
        output chan2_first_lane,
        output chan2_second_lane
    );

    modport rx (
        output sample_strobe_pos,
        output sample_strobe_neg,
        input forwarded_bit_clock,
        input frame_marker,
        input chan1_first_lane,
        input chan1_second_lane,
        input chan2_first_lane,
        input chan2_second_lane
    );
endinterface : dsf_link_if

// File: hw/dsf_sample_fifo.sv
// small synchronous fifo with valid and ready on both sides
`timescale 1ns/1ps
module dsf_sample_fifo #(
    parameter int WIDTH = 26,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0] count_reg;
    wire push = in_valid & in_ready;
    wire pop = out_valid & out_ready;
    wire [AW-1:0] last_ptr = AW'(DEPTH - 1);

    ////////////////////////////////////////////////////////////////////////////
    // honest full and empty from the fill count
    assign in_ready = (count_reg != (AW + 1)'(DEPTH));
    assign out_valid = (count_reg != '0);
    assign out_data = mem[rd_ptr_reg];

    // storage write
    always_ff @(posedge mclk) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data;
        end
    end

    // pointers and count
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == last_ptr) ? '0 : wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == last_ptr) ? '0 : rd_ptr_reg + 1'b1;
            end
            count_reg <= count_reg + (AW + 1)'(push) - (AW + 1)'(pop);
        end
    end
endmodule : dsf_sample_fifo

// File: hw/dsf_rx_end.sv
// deserializer end: makes the strobe, waits out relock, rebuilds words on both clock edges
`timescale 1ns/1ps
module dsf_rx_end #(
    parameter int LOCK_CYCLES = dsf_pkg::PLL_LOCK_CYCLES,
    parameter int STROBE_DIV = dsf_pkg::MAX_STROBE_CYCLES
) (
    // clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // configuration, must match the converter end
    input wire dsf_pkg::dsf_lane_t lane_mode,
    input wire dsf_pkg::dsf_ser_t ser_width,
    // recovered samples
    output logic sample_valid,
    output logic [dsf_pkg::DATA_W-1:0] chan1_sample,
    output logic chan1_over_pos,
    output logic [dsf_pkg::DATA_W-1:0] chan2_sample,
    output logic chan2_over_pos,
    output logic link_locked,
    // serial link
    dsf_link_if.rx link
);
    localparam int LW = $clog2(LOCK_CYCLES + 1);
    localparam int PW = dsf_pkg::PER_W;
    localparam int CW = dsf_pkg::CNT_W;
    localparam int WW = dsf_pkg::WORD_W;

    ////////////////////////////////////////////////////////////////////////////
    // strobe period: long enough for a whole word, never slower than 5 Msps
    wire [CW-1:0] bpl = dsf_pkg::bits_per_lane(lane_mode, ser_width);
    wire [PW-1:0] word_cyc = PW'(bpl) * PW'(dsf_pkg::BIT_DIV) + PW'(dsf_pkg::STROBE_MARGIN);
    wire [PW-1:0] fast_cyc = (word_cyc > PW'(dsf_pkg::GRADE_MIN_CYCLES)) ?
                             word_cyc : PW'(dsf_pkg::GRADE_MIN_CYCLES);
    wire [PW-1:0] want_cyc = (PW'(STROBE_DIV) > fast_cyc) ? PW'(STROBE_DIV) : fast_cyc;
    wire [PW-1:0] period = (want_cyc > PW'(dsf_pkg::MAX_STROBE_CYCLES)) ?
                           PW'(dsf_pkg::MAX_STROBE_CYCLES) : want_cyc;
    wire half_frame = (lane_mode == dsf_pkg::LANES2) & (ser_width == dsf_pkg::SER14);

    logic [PW-1:0] st_cnt_reg;
    logic strobe_reg;
    logic [2:0] cfg_reg;
    logic [LW-1:0] lock_cnt_reg;
    wire cfg_change = (cfg_reg != {lane_mode, ser_width});

    // strobe divider, near even duty
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            st_cnt_reg <= '0;
            strobe_reg <= 1'b0;
        end else begin
            st_cnt_reg <= (st_cnt_reg >= period - 1'b1) ? '0 : st_cnt_reg + 1'b1;
            strobe_reg <= (st_cnt_reg < (period >> 1));
        end
    end

    // relock wait after reset or any change of strobe rate
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            cfg_reg <= '0;
            lock_cnt_reg <= '0;
            link_locked <= 1'b0;
        end else begin
            cfg_reg <= {lane_mode, ser_width};
            if (cfg_change) begin
                lock_cnt_reg <= '0;
            end else if (lock_cnt_reg != LW'(LOCK_CYCLES)) begin
                lock_cnt_reg <= lock_cnt_reg + 1'b1;
            end
            link_locked <= ~cfg_change & (lock_cnt_reg == LW'(LOCK_CYCLES));
        end
    end

    assign link.sample_strobe_pos = strobe_reg;
    assign link.sample_strobe_neg = ~strobe_reg;

    ////////////////////////////////////////////////////////////////////////////
    // link input synchronisers: clock, marker, four lanes
    logic [5:0] s1_reg;
    logic [5:0] s2_reg;
    logic fbc_last_reg;
    logic mk_last_reg;
    logic [CW-1:0] cnt_reg;
    logic [WW-1:0] sh_reg [2];
    logic [WW-1:0] nx_sh [2];

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            s1_reg <= '0;
            s2_reg <= '0;
        end else begin
            s1_reg <= {link.forwarded_bit_clock, link.frame_marker,
                       link.chan1_first_lane, link.chan1_second_lane,
                       link.chan2_first_lane, link.chan2_second_lane};
            s2_reg <= s1_reg;
        end
    end

    // either clock edge takes a bit slot
    wire edge_seen = s2_reg[5] ^ fbc_last_reg;
    wire mk = s2_reg[4];
    wire start = (mk & ~mk_last_reg) | (half_frame & (mk ^ mk_last_reg));
    wire [CW-1:0] nx_cnt = start ? CW'(1) : cnt_reg + 1'b1;
    wire counting = start | ((cnt_reg != '0) & (cnt_reg < bpl));
    wire done = edge_seen & counting & (nx_cnt == bpl);

    // per channel word assembly
    for (genvar c = 0; c < 2; c++) begin : g_chan
        wire [WW-1:0] base = start ? '0 : sh_reg[c];
        wire la = s2_reg[3 - 2 * c];
        wire lb = s2_reg[2 - 2 * c];
        assign nx_sh[c] = (lane_mode == dsf_pkg::LANES2) ? {base[WW-3:0], la, lb}
                                                        : {base[WW-2:0], la};
        always_ff @(posedge mclk or negedge nrst) begin
            if (!nrst) begin
                sh_reg[c] <= '0;
            end else if (edge_seen && counting) begin
                sh_reg[c] <= nx_sh[c];
            end
        end
    end

    wire [dsf_pkg::DATA_W:0] dec1 = dsf_pkg::decode_word(nx_sh[0], ser_width);
    wire [dsf_pkg::DATA_W:0] dec2 = dsf_pkg::decode_word(nx_sh[1], ser_width);

    // slot counter and marker history
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            fbc_last_reg <= 1'b0;
            mk_last_reg <= 1'b0;
            cnt_reg <= '0;
        end else begin
            fbc_last_reg <= s2_reg[5];
            if (edge_seen) begin
                mk_last_reg <= mk;
                cnt_reg <= counting ? nx_cnt : '0;
            end
        end
    end

    // sample outputs, only trusted once locked
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            sample_valid <= 1'b0;
            chan1_sample <= '0;
            chan1_over_pos <= 1'b0;
            chan2_sample <= '0;
            chan2_over_pos <= 1'b0;
        end else begin
            sample_valid <= done & link_locked;
            if (done) begin
                {chan1_over_pos, chan1_sample} <= dec1;
                {chan2_over_pos, chan2_sample} <= dec2;
            end
        end
    end
endmodule : dsf_rx_end

// File: sim/dsf_link_chk.sv
// link checker for the dual converter serial framer
`timescale 1ns/1ps
module dsf_link_chk (
    // clock, reset and modes
    input wire logic mclk,
    input wire logic nrst,
    input wire dsf_pkg::dsf_lane_t lane_mode,
    input wire dsf_pkg::dsf_ser_t ser_width,
    // link signals
    input wire logic sample_strobe_pos,
    input wire logic sample_strobe_neg,
    input wire logic forwarded_bit_clock,
    input wire logic frame_marker,
    input wire logic chan1_first_lane,
    input wire logic chan1_second_lane,
    input wire logic chan2_first_lane,
    input wire logic chan2_second_lane
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    wire logic bclk = forwarded_bit_clock;
    wire logic mark = frame_marker;
    wire logic [3:0] lanes = {chan1_first_lane, chan1_second_lane, chan2_first_lane,
                              chan2_second_lane};
    wire logic h14 = lane_mode == dsf_pkg::LANES2 && ser_width == dsf_pkg::SER14;
    sequence s_mark_up;
        $rose(mark);
    endsequence
    a_strobe_compl: assert property (sample_strobe_neg == !sample_strobe_pos)
        else $error("strobe halves not complementary");
    a_strobe_floor: assert property ($rose(sample_strobe_pos) |->
        ##[1:40] $rose(sample_strobe_pos))
        else $error("strobe period too long");
    a_data_off_edge: assert property ($changed(lanes) |-> $stable(bclk))
        else $error("data moved with clock");
    a_data_held: assert property ($changed(bclk) |-> $stable(lanes))
        else $error("data not held at clock edge");
    a_clk_slot: assert property ($changed(bclk) |=> $stable(bclk))
        else $error("bit slot too short");
    a_mark_clk: assert property ($changed(mark) |=> $changed(bclk))
        else $error("marker not aligned to slot");
    a_mark_min: assert property (s_mark_up |-> mark [*6])
        else $error("marker high too short");
    a_mark_half: assert property (s_mark_up ##0 h14 |-> mark [*8])
        else $error("marker not at half rate");
    a_second_idle: assert property (lane_mode == dsf_pkg::LANES1 |->
        !lanes[2] && !lanes[0])
        else $error("second lane active in one lane mode");
endmodule : dsf_link_chk

// File: sim/dsf_framer_tb.sv
// self-checking bench joining both ends of the serial framer link
`timescale 1ns/1ps
module dsf_framer_tb;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic pms = 1'b1;
    logic dcs_req = 1'b0;
    dsf_pkg::dsf_lane_t lane_mode = dsf_pkg::LANES2;
    dsf_pkg::dsf_ser_t ser_width = dsf_pkg::SER16;
    logic s_valid = 1'b0;
    logic [11:0] d1 = 12'h0, d2 = 12'h0, r1, r2;
    logic o1 = 1'b0, o2 = 1'b0;
    logic s_ready, locked, dcs_active, missed, r_valid, ro1, ro2, r_locked;
    logic [25:0] rxq[$];
    int errors = 0;
    int n_compared = 0;
    dsf_link_if link ();
    always #2.5 mclk = ~mclk;
    dsf_adc_end #(.LOCK_CYCLES(64)) dsf_adc_end_inst (.mclk(mclk), .nrst(nrst),
        .programming_method_select(pms), .dcs_disable_req(dcs_req), .lane_mode(lane_mode),
        .ser_width(ser_width), .sample_valid(s_valid), .sample_ready(s_ready),
        .chan1_sample(d1), .chan1_over_pos(o1), .chan2_sample(d2), .chan2_over_pos(o2),
        .pll_locked(locked), .dcs_active(dcs_active), .sample_missed(missed), .link(link));
    dsf_rx_end #(.LOCK_CYCLES(64)) dsf_rx_end_inst (.mclk(mclk), .nrst(nrst),
        .lane_mode(lane_mode), .ser_width(ser_width), .sample_valid(r_valid),
        .chan1_sample(r1), .chan1_over_pos(ro1), .chan2_sample(r2), .chan2_over_pos(ro2),
        .link_locked(r_locked), .link(link));
    dsf_link_chk dsf_link_chk_inst (.mclk(mclk), .nrst(nrst), .lane_mode(lane_mode),
        .ser_width(ser_width), .sample_strobe_pos(link.sample_strobe_pos),
        .sample_strobe_neg(link.sample_strobe_neg), .forwarded_bit_clock(link.forwarded_bit_clock),
        .frame_marker(link.frame_marker), .chan1_first_lane(link.chan1_first_lane),
        .chan1_second_lane(link.chan1_second_lane), .chan2_first_lane(link.chan2_first_lane),
        .chan2_second_lane(link.chan2_second_lane));
    // collect recovered words
    always @(negedge mclk) if (r_valid === 1'b1) rxq.push_back({ro1, r1, ro2, r2});
    task automatic chk(string what, logic [25:0] exp, logic [25:0] got);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic final_report();
        $display("errors %0d compared %0d", errors, n_compared);
        if (errors == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : final_report
    // reset both ends in a mode and wait for lock
    task automatic restart(dsf_pkg::dsf_lane_t l, dsf_pkg::dsf_ser_t s);
        nrst = 1'b0;
        lane_mode = l;
        ser_width = s;
        repeat (12) @(negedge mclk);
        nrst = 1'b1;
        for (int i = 0; i < 600 && (locked & r_locked) !== 1'b1; i++) @(negedge mclk);
        chk("locks", 26'h1, {25'h0, locked & r_locked});
        rxq.delete();
    endtask : restart
    // offer one word, leave valid up for a following push
    // ready is looked at on the falling edge, where it has settled
    task automatic push(logic [25:0] w);
        {o1, d1, o2, d2} = w;
        s_valid = 1'b1;
        while (s_ready !== 1'b1) @(negedge mclk);
        @(negedge mclk);
    endtask : push
    task automatic pull(string what, logic [25:0] w);
        for (int i = 0; i < 200 && rxq.size() == 0; i++) @(negedge mclk);
        chk(what, w, (rxq.size() > 0) ? rxq.pop_front() : 26'bx);
    endtask : pull
    // every lane count and word width, pad bits cleared in 12 bit
    task automatic t_modes();
        logic [25:0] w;
        for (int m = 0; m < 6; m++) begin
            restart(dsf_pkg::dsf_lane_t'(m / 3), dsf_pkg::dsf_ser_t'(m % 3));
            w = {1'b1, 12'hfff ^ 12'(m * 299), m[0], 12'h5a3 + 12'(m)};
            push(w);
            s_valid = 1'b0;
            pull("mode word", (m % 3 == 2) ? w & 26'h1ffefff : w);
        end
    endtask : t_modes
    // fill the fifo until refused, then drain in order
    task automatic t_fill();
        logic [25:0] q[$];
        int n;
        restart(dsf_pkg::LANES1, dsf_pkg::SER16);
        for (n = 0; n < 12 && s_ready === 1'b1; n++) begin
            q.push_back({1'b0, 12'(n * 37 + 1), 1'b1, 12'hfff - 12'(n)});
            push(q[n]);
        end
        s_valid = 1'b0;
        chk("ready when full", 26'h0, {25'h0, s_ready});
        foreach (q[i]) pull("fifo word", q[i]);
        for (n = 0; n < 100 && missed !== 1'b1; n++) @(negedge mclk);
        chk("missed", 26'h1, {25'h0, missed});
    endtask : t_fill
    // stabilizer only switched off under serial programming
    task automatic t_dcs();
        dcs_req = 1'b1;
        repeat (4) @(negedge mclk);
        chk("dcs strapped", 26'h1, {25'h0, dcs_active});
        pms = 1'b0;
        repeat (4) @(negedge mclk);
        chk("dcs serial", 26'h0, {25'h0, dcs_active});
        push(26'h2abc123);
        s_valid = 1'b0;
        pull("dcs off word", 26'h2abc123);
    endtask : t_dcs
    initial begin
        t_modes();
        t_fill();
        t_dcs();
        final_report();
    end
    initial begin
        #200000;
        errors++;
        final_report();
    end
endmodule : dsf_framer_tb
